// >>> design/nfca_map.svh
// register map, field positions and fixed figures of the type A framer
// assumes the includer uses these names only inside design logic
// What this block does
// - tx speed field, bits 5:4 of the rate register, sets transmit bit rate
// - rx speed field, bits 1:0 of the rate register, sets receive bit rate
// - codes 0..3 give carrier/128, /64, /32, /16; others unused
// - an unsupported speed code disables only its own direction, transmit or receive
// - parity-suppress bit 7 sends raw bytes without parity bits
// - raw-receive bit 6 stores every bit, no parity/CRC check, 106k only
// - transport bit 5 adds F0 and length on tx, drops F0 on rx, except in detection mode
// - pulse-width field bits 4:1 sets modulation pulse in carrier periods
// - /128: 35 plus signed field; /64: 18 plus signed field, -6..6
// - /32: 9 plus signed field, -4..4; /16: 5 plus signed, -3..3
// - frame bit 0 picks standard frames or bit-split anticollision frames on rx; tx always sends whole bytes
// - detection mode is target with top mode bit set; low bits pick protocols
`ifndef NFCA_MAP_SVH
`define NFCA_MAP_SVH
`define RATE_IDX    6'h04
`define FRAME_IDX   6'h05
`define STAT_IDX    6'h06
`define RATE_WMASK  8'h33
`define FRAME_WMASK 8'hFF
`define REG_RST     8'h00
`define TXRATE_LSB  4
`define RXRATE_LSB  0
`define NOTXPAR_BIT 7
`define RAWRX_BIT   6
`define TFRAME_BIT  5
`define PLEN_LSB    1
`define ANTCL_BIT   0
`define SOF_BYTE    8'hF0
`define DIV_128     8'h80
`define DIV_64      8'h40
`define DIV_32      8'h20
`define DIV_16      8'h10
`define PW_BASE0    7'h23
`define PW_BASE1    7'h12
`define PW_BASE2    7'h09
`define PW_BASE3    7'h05
`define PW_LIM1     5'h06
`define PW_LIM2     5'h04
`define PW_LIM3     5'h03
`define BITS_PAR    4'h9
`define BITS_RAW    4'h8
`define RESP_OK     2'h0
`define RESP_ERR    2'h2
`endif

// >>> design/nfca_pkg.sv
// types shared by the framer files
// assumes nothing; compiled before the modules
package nfca_pkg;
  typedef logic [1:0] rate_t;
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_LOAD  = 3'b010,
    TX_SHIFT = 3'b100
  } txState_e;
endpackage

// >>> design/rate_decode.sv
// speed code to carrier divider, with a supported flag
// assumes a 4-bit code, upper bits zero for the 2-bit fields
`timescale 1ns/1ns
`default_nettype none
`include "nfca_map.svh"
module rate_decode (
  input  wire logic [3:0] code,  // speed code
  output logic      [7:0] div,   // carrier periods per bit
  output logic            ok     // code is supported
);
  // unused codes give no divider, so the caller can stop
  always_comb
  begin
    ok = 1'b1;
    case (code)
      4'h0: div = `DIV_128;
      4'h1: div = `DIV_64;
      4'h2: div = `DIV_32;
      4'h3: div = `DIV_16;
      default:
      begin
        div = 8'h00;
        ok  = 1'b0;
      end
    endcase
  end
endmodule // rate_decode
`default_nettype wire

// >>> design/pulse_width_calc.sv
// modulation pulse width from the signed field and the tx rate
// assumes rate is a supported 2-bit code
`timescale 1ns/1ns
`default_nettype none
`include "nfca_map.svh"
module pulse_width_calc (
  input  wire logic [3:0] plen,   // signed pulse field
  input  wire logic [1:0] rate,   // tx speed code
  output logic      [5:0] width,  // carrier periods
  output logic            ok      // code available at this rate
);
  logic signed [4:0] sv;
  logic signed [4:0] lim;
  logic        [6:0] base;
  logic        [6:0] sum;
  assign sv = $signed({plen[3], plen});
  // base and allowed span per rate
  always_comb
  begin
    lim  = 5'sh08;
    base = `PW_BASE0;
    case (rate)
      2'h1:
      begin
        base = `PW_BASE1;
        lim  = $signed(`PW_LIM1);
      end
      2'h2:
      begin
        base = `PW_BASE2;
        lim  = $signed(`PW_LIM2);
      end
      2'h3:
      begin
        base = `PW_BASE3;
        lim  = $signed(`PW_LIM3);
      end
      default: lim = 5'sh08;
    endcase
  end
  assign sum   = base + {{2{sv[4]}}, sv};
  assign width = sum[5:0];
  assign ok    = (sv <= lim) && (sv >= -lim);
endmodule // pulse_width_calc
`default_nettype wire

// >>> design/nfca_rate_and_framing_config.sv
// type A rate and framing block: AXI4-Lite registers, tx serialiser, rx packer
// assumes fcTick, rx bits and byte source come from logic on mclk
`timescale 1ns/1ns
`default_nettype none
`include "nfca_map.svh"
module nfca_rate_and_framing_config (
  input  wire logic        mclk,          // 20 MHz clock
  input  wire logic        rst_b,         // async reset, low
  input  wire logic [7:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // byte enables
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [7:0]  s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  input  wire logic [3:0]  opMode,        // mode bits, top bit first
  input  wire logic        targetMode,    // device acts as target
  output logic             autoDetect,    // bit rate detection active
  output logic             detectTypeA,   // type A detection enabled
  output logic             detectTypeF,   // type F detection enabled
  input  wire logic        fcTick,        // one pulse per carrier period
  input  wire logic        txStart,       // start a frame
  input  wire logic [7:0]  txLen,         // data bytes in frame
  input  wire logic [7:0]  txData,        // byte from fifo
  input  wire logic        txValid,       // byte offered
  output logic             txReady,       // byte taken
  output logic             txBusy,        // frame in progress
  output logic             txBit,         // current bit
  output logic             txMod,         // modulation pulse
  output logic [7:0]       rxDiv,         // expected rx bit period
  input  wire logic        rxBit,         // demodulated bit
  input  wire logic        rxBitStb,      // bit strobe
  input  wire logic        rxFrameEnd,    // end of rx frame
  output logic [7:0]       rxData,        // received byte
  output logic [3:0]       rxBits,        // valid bits in rxData
  output logic             rxDataValid,   // byte pulse
  output logic             rxParErr       // parity error seen
);
  logic [1:0]  rstSync;
  logic        rstn;
  logic [7:0]  rateReg_ff;
  logic [7:0]  frameReg_ff;
  logic        parErr_ff;
  logic [7:0]  txDiv;
  logic        txRateOk;
  logic        rxRateOk;
  logic [5:0]  pulseW;
  logic        pulseOk;
  logic        tframe;
  logic        rawRx;
  // release the reset through two flops
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      rstSync <= 2'h0;
    else
      rstSync <= {rstSync[0], 1'b1};
  end
  assign rstn = rstSync[1];
  // rate decoders, one per direction
  rate_decode uTxRate (
    .code ({2'h0, rateReg_ff[`TXRATE_LSB +: 2]}),
    .div  (txDiv),
    .ok   (txRateOk)
  );
  rate_decode uRxRate (
    .code ({2'h0, rateReg_ff[`RXRATE_LSB +: 2]}),
    .div  (rxDiv),
    .ok   (rxRateOk)
  );
  pulse_width_calc uPw (
    .plen  (frameReg_ff[`PLEN_LSB +: 4]),
    .rate  (rateReg_ff[`TXRATE_LSB +: 2]),
    .width (pulseW),
    .ok    (pulseOk)
  );
  // detection mode decode; transport frame forced off there as a guard
  assign autoDetect  = targetMode & opMode[3];
  assign detectTypeA = autoDetect & opMode[0];
  assign detectTypeF = autoDetect & opMode[2];
  assign tframe = frameReg_ff[`TFRAME_BIT] & ~autoDetect;
  // raw receive only at the slowest rate
  assign rawRx = frameReg_ff[`RAWRX_BIT] && rateReg_ff[`RXRATE_LSB +: 2] == 2'h0;

  // bus write side: address and data taken in either order
  logic        awHeld;
  logic        wHeld;
  logic [5:0]  awIdx;
  logic [31:0] wDat;
  logic [3:0]  wStb;
  logic        doWrite;
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awIdx  <= 6'h00;
      wDat   <= 32'h0;
      wStb   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld <= 1'b1;
        awIdx  <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld <= 1'b1;
        wDat  <= s_axi_wdata;
        wStb  <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHeld <= 1'b0;
        wHeld  <= 1'b0;
      end
    end
  end
  // write response one cycle after both halves are held
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OK;
    end
    else if (doWrite)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awIdx == `RATE_IDX || awIdx == `FRAME_IDX ||
                       awIdx == `STAT_IDX) ? `RESP_OK : `RESP_ERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end
  // configuration registers; reserved bits never store
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rateReg_ff  <= `REG_RST;
      frameReg_ff <= `REG_RST;
    end
    else if (doWrite && wStb[0])
    begin
      if (awIdx == `RATE_IDX)
        rateReg_ff <= wDat[7:0] & `RATE_WMASK;
      if (awIdx == `FRAME_IDX)
        frameReg_ff <= wDat[7:0] & `FRAME_WMASK;
    end
  end
  // parity error flag: hardware set beats write-one clear
  logic parSet;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      parErr_ff <= 1'b0;
    else if (parSet)
      parErr_ff <= 1'b1;
    else if (doWrite && wStb[0] && awIdx == `STAT_IDX && wDat[4])
      parErr_ff <= 1'b0;
  end
  assign rxParErr = parErr_ff;
  // read side: one read at a time, data from a flop
  logic [7:0] rdMux;
  logic       rdHit;
  always_comb
  begin
    rdHit = 1'b1;
    case (s_axi_araddr[7:2])
      `RATE_IDX:  rdMux = rateReg_ff;
      `FRAME_IDX: rdMux = frameReg_ff;
      `STAT_IDX:  rdMux = {3'h0, parErr_ff, pulseOk, txBusy, rxRateOk, txRateOk};
      default:
      begin
        rdMux = 8'h00;
        rdHit = 1'b0;
      end
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h0, rdMux};
      s_axi_rresp  <= rdHit ? `RESP_OK : `RESP_ERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // bit timing from carrier periods at the tx rate
  logic [7:0] divCnt;
  logic       bitTick;
  assign bitTick = fcTick && divCnt == txDiv - 8'h01;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      divCnt <= 8'h00;
    else if (!txBusy || bitTick)
      divCnt <= 8'h00;
    else if (fcTick)
      divCnt <= divCnt + 8'h01;
  end
  // tx sequencer: header bytes, then fifo bytes
  nfca_pkg::txState_e txState;
  logic [1:0]  hdrCnt;
  logic [7:0]  remain;
  logic [8:0]  shiftReg;
  logic [3:0]  bitsLeft;
  logic [7:0]  lenByte;
  logic [7:0]  hdrByte;
  logic        takeByte;
  assign lenByte  = txLen + 8'h01;
  assign hdrByte  = (hdrCnt == 2'h2) ? `SOF_BYTE : lenByte;
  assign takeByte = txState == nfca_pkg::TX_LOAD && hdrCnt == 2'h0
                    && remain != 8'h00 && txValid;
  assign txReady  = takeByte;
  assign txBusy   = txState != nfca_pkg::TX_IDLE;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      txState  <= nfca_pkg::TX_IDLE;
      hdrCnt   <= 2'h0;
      remain   <= 8'h00;
      shiftReg <= 9'h000;
      bitsLeft <= 4'h0;
    end
    else if (!txRateOk)
      txState <= nfca_pkg::TX_IDLE;
    else
    begin
      case (txState)
        nfca_pkg::TX_IDLE:
          if (txStart)
          begin
            txState <= nfca_pkg::TX_LOAD;
            remain  <= txLen;
            hdrCnt  <= tframe ? 2'h2 : 2'h0;
          end
        nfca_pkg::TX_LOAD:
          if (hdrCnt != 2'h0 || takeByte)
          begin
            txState  <= nfca_pkg::TX_SHIFT;
            // odd parity in bit 8 unless suppressed
            shiftReg <= hdrCnt != 2'h0 ? {~^hdrByte, hdrByte} : {~^txData, txData};
            bitsLeft <= frameReg_ff[`NOTXPAR_BIT] ? `BITS_RAW : `BITS_PAR;
            if (hdrCnt != 2'h0)
              hdrCnt <= hdrCnt - 2'h1;
            else
              remain <= remain - 8'h01;
          end
          else if (remain == 8'h00)
            txState <= nfca_pkg::TX_IDLE;
        nfca_pkg::TX_SHIFT:
          if (bitTick)
          begin
            shiftReg <= {1'b0, shiftReg[8:1]};
            bitsLeft <= bitsLeft - 4'h1;
            if (bitsLeft == 4'h1)
              txState <= nfca_pkg::TX_LOAD;
          end
        default: txState <= nfca_pkg::TX_IDLE;
      endcase
    end
  end
  // output bit and modulation pulse held in flops
  logic [5:0] modCnt;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      txBit  <= 1'b0;
      txMod  <= 1'b0;
      modCnt <= 6'h00;
    end
    else
    begin
      txBit <= txState == nfca_pkg::TX_SHIFT && shiftReg[0];
      // a pause at the start of each zero bit but the first of a byte, which begins with divCnt already past zero
      if (txState == nfca_pkg::TX_SHIFT && divCnt == 8'h00 && fcTick
          && !txMod && !shiftReg[0])
      begin
        txMod  <= 1'b1;
        modCnt <= 6'h00;
      end
      else if (txMod && fcTick)
      begin
        modCnt <= modCnt + 6'h01;
        if (modCnt == pulseW - 6'h01)
          txMod <= 1'b0;
      end
    end
  end

  // rx packer: 9 bits per byte normally, 8 in raw mode
  logic [8:0] rxSr;
  logic [3:0] rxCnt;
  logic       rxFirst;
  logic [3:0] need;
  logic [8:0] nxt_rxSr;
  logic       byteDone;
  logic       dropSof;
  assign need     = rawRx ? `BITS_RAW : `BITS_PAR;
  assign nxt_rxSr = {rxBit, rxSr[8:1]};
  assign byteDone = rxBitStb && rxRateOk && rxCnt == need - 4'h1;
  assign dropSof  = tframe && rxFirst &&
                    (rawRx ? nxt_rxSr[8:1] : nxt_rxSr[7:0]) == `SOF_BYTE;
  assign parSet   = byteDone && !rawRx && ^nxt_rxSr == 1'b0;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rxSr        <= 9'h000;
      rxCnt       <= 4'h0;
      rxFirst     <= 1'b1;
      rxData      <= 8'h00;
      rxBits      <= 4'h0;
      rxDataValid <= 1'b0;
    end
    else
    begin
      rxDataValid <= 1'b0;
      if (!rxRateOk || rxFrameEnd)
      begin
        // bit-split frame: keep the partial byte
        if (rxRateOk && frameReg_ff[`ANTCL_BIT] && rxCnt != 4'h0)
        begin
          rxData      <= rxSr[8:1] >> (4'h8 - rxCnt);
          rxBits      <= rxCnt;
          rxDataValid <= 1'b1;
        end
        rxCnt   <= 4'h0;
        rxFirst <= 1'b1;
      end
      else if (rxBitStb)
      begin
        rxSr  <= nxt_rxSr;
        rxCnt <= rxCnt + 4'h1;
        if (byteDone)
        begin
          rxCnt   <= 4'h0;
          rxFirst <= 1'b0;
          rxData  <= rawRx ? nxt_rxSr[8:1] : nxt_rxSr[7:0];
          rxBits  <= `BITS_RAW;
          rxDataValid <= !dropSof;
        end
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_tx_stop: assert property (!txRateOk |=> !txBusy)
    else $error("tx running with unsupported rate");
  a_tx_div: assert property (rateReg_ff[5:4] == 2'h0 |-> txDiv == `DIV_128)
    else $error("tx divider wrong for slowest rate");
  a_rx_div: assert property (rateReg_ff[1:0] == 2'h3 |-> rxDiv == `DIV_16)
    else $error("rx divider wrong for fastest rate");
  a_div_map: assert property (rateReg_ff[5:4] == 2'h2 |-> txDiv == `DIV_32)
    else $error("divider map wrong");
  a_par_count: assert property (txState == nfca_pkg::TX_LOAD && takeByte
      |=> bitsLeft == (frameReg_ff[7] ? 4'h8 : 4'h9))
    else $error("bit count per byte wrong");
  a_raw_pack: assert property (rawRx && rxRateOk && !rxFrameEnd && rxBitStb
      && rxCnt == 4'h7 && !dropSof |=> rxDataValid && rxBits == 4'h8)
    else $error("raw byte not delivered after eight bits");
  a_sof_first: assert property (txState == nfca_pkg::TX_LOAD && hdrCnt == 2'h2
      |=> shiftReg[7:0] == `SOF_BYTE)
    else $error("start byte not sent first");
  a_pulse_len: assert property (txMod && fcTick && modCnt == pulseW - 6'h01
      |=> !txMod)
    else $error("pulse longer than set");
  a_pulse_base: assert property (rateReg_ff[5:4] == 2'h0 && frameReg_ff[4:1] == 4'h7
      |-> pulseW == 6'h2A)
    else $error("pulse width at slow rate wrong");
  a_pulse_fast: assert property (rateReg_ff[5:4] == 2'h3 && frameReg_ff[4:1] == 4'hD
      |-> pulseW == 6'h02 && pulseOk)
    else $error("pulse width at fast rate wrong");
  a_antcl_part: assert property (rxFrameEnd && rxRateOk && frameReg_ff[0]
      && rxCnt == 4'h3 |=> rxDataValid && rxBits == 4'h3)
    else $error("partial anticollision byte lost");
  a_rsvd_zero: assert property ((rateReg_ff & ~`RATE_WMASK) == 8'h00
      && ($stable(rateReg_ff) || $past(doWrite)))
    else $error("reserved rate bits set");
  c_tx_frame: cover property (txBusy && tframe ##1 txState == nfca_pkg::TX_SHIFT);
  c_rx_byte: cover property (rxDataValid && !rawRx);
  c_antcl: cover property (rxDataValid && rxBits != 4'h8);
endmodule // nfca_rate_and_framing_config
`default_nettype wire

// >>> verif/nfca_peer.sv
// card-side model: carrier ticks, tx byte source, rx bit stream
// assumes the framer samples these on rising mclk edges
`timescale 1ns/1ns
`default_nettype none
module nfca_peer (
  input  wire logic       mclk,       // framer clock
  input  wire logic       txReady,    // byte taken
  output logic            fcTick,     // carrier tick
  output logic      [7:0] txData,     // offered byte
  output logic            txValid,    // byte offered
  output logic            rxBit,      // received bit
  output logic            rxBitStb,   // bit strobe
  output logic            rxFrameEnd  // frame end pulse
);
  int taken = 0;  // bytes handed over
  int stall = 0;  // idle cycles before an offer
  int idle  = 0;  // idle cycles so far
  // a tick every clock, so carrier periods read directly as cycles
  initial
  begin
    fcTick     = 1'b1;
    txData     = 8'h5A;
    txValid    = 1'b0;
    rxBit      = 1'b0;
    rxBitStb   = 1'b0;
    rxFrameEnd = 1'b0;
  end
  // byte source; bus shows the inverse byte while nothing is offered
  always @(posedge mclk)
  begin
    if (txValid && txReady)
    begin
      taken++;
      idle = 0;
      txValid <= 1'b0;
      txData  <= 8'h5A;
    end
    else if (!txValid)
    begin
      idle++;
      if (idle > stall)
      begin
        txValid <= 1'b1;
        txData  <= 8'hA5;
      end
    end
  end
  // lsb first; line inverted between strobes so no stale bit is read
  task automatic send_bits(input logic [8:0] v, input int n, input logic fin);
    for (int i = 0; i < n; i++)
    begin
      @(posedge mclk);
      rxBit    <= v[i];
      rxBitStb <= 1'b1;
      @(posedge mclk);
      rxBit    <= ~v[i];
      rxBitStb <= 1'b0;
    end
    if (fin)
    begin
      @(posedge mclk);
      rxFrameEnd <= 1'b1;
      @(posedge mclk);
      rxFrameEnd <= 1'b0;
    end
  endtask
endmodule // nfca_peer
`default_nettype wire

// >>> verif/tb.sv
// self-checking bench for the type A rate and framing block
// assumes the card model nfca_peer; assertions live in the design
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic mclk = 0, rst_b = 0, txStart = 0, targetMode = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, autoDetect, detectTypeA, detectTypeF;
  logic txValid, txReady, txBusy, txBit, txMod, rxBit, rxBitStb, rxFrameEnd, fcTick;
  logic rxDataValid, rxParErr;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb = 4'hF, opMode = 4'h1, rxBits;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, txLen = 0, txData, rxDiv, rxData;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  int          error_cnt = 0, total_checks = 0;
  logic [11:0] rxq[$];  // received {bits, byte}

  always #25 mclk = ~mclk;

  nfca_rate_and_framing_config i_nfca_rate_and_framing_config (.mclk, .rst_b, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .opMode, .targetMode, .autoDetect,
    .detectTypeA, .detectTypeF, .fcTick, .txStart, .txLen, .txData, .txValid, .txReady, .txBusy,
    .txBit, .txMod, .rxDiv, .rxBit, .rxBitStb, .rxFrameEnd, .rxData, .rxBits, .rxDataValid,
    .rxParErr);
  nfca_peer i_nfca_peer (.mclk, .txReady, .fcTick, .txData, .txValid, .rxBit, .rxBitStb,
    .rxFrameEnd);

  // collect every byte pulse, so an unexpected one is never missed
  always @(posedge mclk)
    if (rxDataValid === 1'b1) rxq.push_back({rxBits, rxData});

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic hang(input string m);
    chk(0, 1, m);
    close_out();
  endtask

  // both halves offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 40) hang("write timeout");
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 40) hang("read timeout");
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    axr(8'h10, d, r);
    chk(d, 32'h0, "rate reset");
    axr(8'h14, d, r);
    chk(d, 32'h0, "framing reset");
    axw(8'h10, 32'hFF, r);
    axr(8'h10, d, r);
    chk(d, 32'h33, "rate reserved bits");
    axw(8'h3C, 32'h1, r);
    chk(r, 2'h2, "unmapped write");
    axr(8'h3C, d, r);
    chk({r, d[29:0]}, 32'h80000000, "unmapped read");
    $display("t_regs done");
  endtask

  task automatic t_rates();
    logic [31:0] d;
    logic [1:0]  r;
    for (int c = 0; c < 4; c++)
    begin
      axw(8'h10, {26'h0, c[1:0], 2'h0, c[1:0]}, r);
      chk(rxDiv, 32'h80 >> c, "rx divider");
      axr(8'h18, d, r);
      chk(d[1:0], 2'h3, "rates supported");
    end
    $display("t_rates done");
  endtask

  task automatic t_detect();
    for (int i = 0; i < 32; i++)
    begin
      @(posedge mclk);
      targetMode <= i[4];
      opMode     <= i[3:0];
      @(posedge mclk);
      chk(autoDetect, i[4] & i[3], "detect mode");
      chk(detectTypeA, i[4] & i[3] & i[0], "type A detect");
      chk(detectTypeF, i[4] & i[3] & i[2], "type F detect");
    end
    $display("t_detect done");
  endtask

  // set framing, then let the card send bits
  task automatic rxs(input logic [7:0] f, input logic [8:0] v, input int n, input logic e);
    logic [1:0] r;
    axw(8'h14, {24'h0, f}, r);
    rxq.delete();
    i_nfca_peer.send_bits(v, n, e);
    repeat (3) @(posedge mclk);
  endtask

  task automatic t_rx();
    logic [31:0] d;
    logic [1:0]  r;
    opMode     <= 4'h1;
    targetMode <= 1'b0;
    axw(8'h10, 32'h0, r);
    rxs(8'h00, 9'h15A, 9, 1'b0);
    chk({24'(rxq.size()), rxq[0][7:0]}, 32'h15A, "odd parity byte");
    rxs(8'h00, 9'h05A, 9, 1'b0);
    axr(8'h18, d, r);
    chk({d[4], rxParErr}, 2'h3, "parity error flag");
    axw(8'h18, 32'h10, r);
    rxs(8'h40, 9'h05A, 8, 1'b1);
    axr(8'h18, d, r);
    chk({23'(rxq.size()), d[4], rxq[0][7:0]}, 32'h25A, "raw byte, no check");
    rxs(8'h20, 9'h1F0, 9, 1'b0);
    chk(rxq.size(), 0, "start byte dropped");
    rxs(8'h20, 9'h133, 9, 1'b1);
    chk({24'(rxq.size()), rxq[0][7:0]}, 32'h133, "byte after start");
    opMode     <= 4'h8;
    targetMode <= 1'b1;
    rxs(8'h20, 9'h1F0, 9, 1'b1);
    chk(rxq[0][7:0], 8'hF0, "start byte kept in detect");
    opMode     <= 4'h1;
    targetMode <= 1'b0;
    rxs(8'h01, 9'h005, 3, 1'b1);
    chk(rxq[0], {4'h3, 8'h05}, "partial byte");
    axw(8'h14, 32'h0, r);
    $display("t_rx done");
  endtask

  task automatic t_pulse();
    logic [7:0] fr[7] = '{8'h26, 8'h9A, 8'h0E, 8'h10, 8'h0C, 8'h14, 8'h08};
    int rc[7] = '{3, 3, 0, 0, 1, 1, 2};
    int pw[7] = '{8, 2, 42, 27, 24, 12, 13};
    int nb, e, busy, run, first, t0, n, hi, bad;
    logic [1:0] r;
    logic [31:0] d;
    for (int k = 0; k < 7; k++)
    begin
      axw(8'h10, {26'h0, rc[k][1:0], 2'h0, rc[k][1:0]}, r);
      axw(8'h14, {24'h0, fr[k]}, r);
      axr(8'h18, d, r);
      chk(d[3], 1'b1, "pulse code available");
      i_nfca_peer.stall = 5 * (k % 2);
      nb = fr[k][5] ? 3 : 1;
      e = nb * (fr[k][7] ? 8 : 9) * (128 >> rc[k]);
      t0 = i_nfca_peer.taken;
      busy = 0;
      run = 0;
      first = 0;
      hi = 0;
      bad = 0;
      @(posedge mclk);
      txStart <= 1'b1;
      txLen   <= 8'h01;
      @(posedge mclk);
      txStart <= 1'b0;
      // first pause length and frame length in one pass
      for (n = 0; n < 5000; n++)
      begin
        @(posedge mclk);
        if (txBit === 1'b1) hi++;
        if (txMod === 1'b1 && txBit !== 1'b0) bad++;
        if (txMod === 1'b1) run++;
        else if (run > 0 && first == 0) first = run;
        if (txBusy !== 1'b1) break;
        busy++;
      end
      if (n == 5000) hang("tx timeout");
      chk(busy >= e && busy <= e + 3 * nb + 8, 1, "frame length");
      chk(first, pw[k], "pulse width");
      chk(hi > 0 && bad == 0, 1, "pause only on zero bits");
      chk(i_nfca_peer.taken - t0, 1, "data bytes taken");
    end
    $display("t_pulse done");
  endtask

  // reset, then scenarios in turn
  initial
  begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    t_regs();
    t_rates();
    t_detect();
    t_rx();
    t_pulse();
    close_out();
  end
endmodule // tb
`default_nettype wire
